/* File: pm_defs.vh */
`ifndef PM_DEFS_VH
`define PM_DEFS_VH

// Power modes
`define MODE_NORMAL   2'h0
`define MODE_PARTIAL  2'h1
`define MODE_FULL     2'h2
`define MODE_W        2

// Falling-edge counts that frame the mode window
`define EDGE_GLITCH   6'h02
`define EDGE_KEEP     6'h0A
`define EDGE_TRACK    6'h0D
`define EDGE_FIRST    6'h0E
`define EDGE_ZEROS    6'h10
`define EDGE_SECOND   6'h1E
`define EDGE_RELEASE  6'h20
`define CNT_W         6

// Result layout
`define RES_W         12
`define RES_MSB       11
`define FRAME_W       16

// Partial wake time: 200 ns counted in 10 ns clock cycles
`define WAKE_CYC      5'h14
`define WAKE_W        5

`endif

/* File: adc_power_mode_control.v */
`timescale 1ns/1ns
`default_nettype none
`include "pm_defs.vh"

module adc_power_mode_control (
   input  wire                I_CLK_SYS,       // System clock, 100 MHz
   input  wire                I_RESETN,        // Synchronous reset, active low
   input  wire                I_CS_N,          // Chip select from host, async
   input  wire                I_SCLK,          // Serial clock from host, async
   input  wire [`RES_MSB:0]   I_RESULT_A,      // Channel A result, unsigned binary
   input  wire [`RES_MSB:0]   I_RESULT_B,      // Channel B result, unsigned binary
   output reg                 O_SERIAL_OUT_FIRST,     // Data line one level
   output reg                 O_SERIAL_OUT_FIRST_OE,  // Data line one enable
   output reg                 O_SERIAL_OUT_SECOND,    // Data line two level
   output reg                 O_SERIAL_OUT_SECOND_OE, // Data line two enable
   output reg                 O_SAMPLE,        // Pulse: sample both inputs
   output reg                 O_TRACK,         // Track-and-hold in track
   output reg                 O_ANALOG_EN,     // Converter analog enable
   output reg                 O_REF_EN,        // Reference and buffers enable
   output reg  [`MODE_W-1:0]  O_MODE,          // Current power mode
   output reg                 O_READY          // Converter fully powered
);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Two stages settle the pins; the third is only the edge detector's history
   reg                cs_m_r, cs_s_r, cs_d_r;
   reg                sc_m_r, sc_s_r, sc_d_r;
   wire               cs_fall = cs_d_r & ~cs_s_r;
   wire               cs_rise = ~cs_d_r & cs_s_r;
   wire               sc_fall = sc_d_r & ~sc_s_r;
   wire               sc_rise = ~sc_d_r & sc_s_r;

   always @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         // Host parks the serial clock high, so release shows no false edge
         sc_m_r <= 1'b1;
         sc_s_r <= 1'b1;
         sc_d_r <= 1'b1;
      end else begin
         cs_m_r <= I_CS_N;
         cs_s_r <= cs_m_r;
         cs_d_r <= cs_s_r;
         sc_m_r <= I_SCLK;
         sc_s_r <= sc_m_r;
         sc_d_r <= sc_s_r;
      end
   end

   // ---------------------------------------------------------------
   // Frame state
   // ---------------------------------------------------------------
   reg  [`CNT_W-1:0]   cnt_r;
   reg                 active_r;
   reg  [`FRAME_W-1:0] sh_a_r, sh_b_r;
   reg  [`RES_MSB:0]   hold_a_r, hold_b_r;
   reg  [`MODE_W-1:0]  mode_r;
   reg                 wake_r;
   reg  [`WAKE_W-1:0]  wake_cnt_r;
   reg                 track_pend_r;

   // ---------------------------------------------------------------
   // Mode decision at select rise
   // ---------------------------------------------------------------
   // Judged from the count reached when select rises; a frame shorter
   // than two edges counts as a glitch, so noise on select never
   // changes the mode
   reg  [`MODE_W-1:0]  mode_nxt;

   always @* begin
      if (cnt_r < `EDGE_GLITCH) begin
         mode_nxt = mode_r;              // Glitch keeps the mode
      end else if (cnt_r < `EDGE_KEEP) begin
         if (mode_r == `MODE_NORMAL) begin
            mode_nxt = `MODE_PARTIAL;
         end else begin
            mode_nxt = `MODE_FULL;
         end
      end else begin
         mode_nxt = `MODE_NORMAL;
      end
   end

   // Power-on mode is undefined in the part; reset picks normal as a safe start
   always @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         cnt_r        <= {`CNT_W{1'b0}};
         active_r     <= 1'b0;
         sh_a_r       <= {`FRAME_W{1'b0}};
         sh_b_r       <= {`FRAME_W{1'b0}};
         hold_a_r     <= {`RES_W{1'b0}};
         hold_b_r     <= {`RES_W{1'b0}};
         mode_r       <= `MODE_NORMAL;
         wake_r       <= 1'b0;
         wake_cnt_r   <= {`WAKE_W{1'b0}};
         track_pend_r <= 1'b0;
         O_SERIAL_OUT_FIRST     <= 1'b0;
         O_SERIAL_OUT_FIRST_OE  <= 1'b0;
         O_SERIAL_OUT_SECOND    <= 1'b0;
         O_SERIAL_OUT_SECOND_OE <= 1'b0;
         O_SAMPLE     <= 1'b0;
         O_TRACK      <= 1'b1;
      end else begin
         O_SAMPLE <= 1'b0;
         if (cs_fall) begin
            // Sample, start, drive leading zero
            cnt_r    <= {`CNT_W{1'b0}};
            active_r <= 1'b1;
            O_SAMPLE <= 1'b1;
            O_TRACK  <= 1'b0;
            hold_a_r <= I_RESULT_A;  // Unsigned binary codes
            hold_b_r <= I_RESULT_B;
            // Two zeros lead the twelve bits and two trail them; the reload
            // at edge 16 repeats the layout for the other channel
            sh_a_r   <= {2'h0, I_RESULT_A, 2'h0};
            sh_b_r   <= {2'h0, I_RESULT_B, 2'h0};
            O_SERIAL_OUT_FIRST     <= 1'b0;
            O_SERIAL_OUT_SECOND    <= 1'b0;
            O_SERIAL_OUT_FIRST_OE  <= 1'b1;
            O_SERIAL_OUT_SECOND_OE <= 1'b1;
            // Powering up begins at the fall
            wake_r       <= (mode_r != `MODE_NORMAL);
            wake_cnt_r   <= {`WAKE_W{1'b0}};
            track_pend_r <= (mode_r == `MODE_PARTIAL);
         end else if (cs_rise && active_r) begin
            // Rise ends the frame and releases both lines
            active_r <= 1'b0;
            O_SERIAL_OUT_FIRST_OE  <= 1'b0;
            O_SERIAL_OUT_SECOND_OE <= 1'b0;
            O_TRACK      <= 1'b1;
            wake_r       <= 1'b0;
            track_pend_r <= 1'b0;
            // Dropping wake_r above undoes a glitch's power-up
            mode_r       <= mode_nxt;
         end else if (active_r) begin
            if (wake_r && wake_cnt_r != `WAKE_CYC)
               wake_cnt_r <= wake_cnt_r + 1'b1;
            // First clock edge after fall while waking from partial
            if (track_pend_r && (sc_fall || sc_rise)) begin
               O_TRACK      <= 1'b1;
               track_pend_r <= 1'b0;
            end
            // Back to track on the rising edge after edge 13
            if (sc_rise && cnt_r == `EDGE_TRACK)
               O_TRACK <= 1'b1;
            // Count stops at 32 so select may idle low without the frame wrapping
            if (sc_fall && cnt_r != `EDGE_RELEASE) begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r + 1'b1 == `EDGE_RELEASE) begin
                  // Line released on edge 32; select may idle low
                  O_SERIAL_OUT_FIRST_OE  <= 1'b0;
                  O_SERIAL_OUT_SECOND_OE <= 1'b0;
               end else if (cnt_r + 1'b1 == `EDGE_ZEROS) begin
                  // Chain the other channel after the two zeros
                  sh_a_r <= {2'h0, hold_b_r, 2'h0};
                  sh_b_r <= {2'h0, hold_a_r, 2'h0};
                  O_SERIAL_OUT_FIRST  <= 1'b0;
                  O_SERIAL_OUT_SECOND <= 1'b0;
               end else begin
                  // MSB first, zeros after bit 14
                  sh_a_r <= {sh_a_r[`FRAME_W-2:0], 1'b0};
                  sh_b_r <= {sh_b_r[`FRAME_W-2:0], 1'b0};
                  O_SERIAL_OUT_FIRST  <= sh_a_r[`FRAME_W-2];
                  O_SERIAL_OUT_SECOND <= sh_b_r[`FRAME_W-2];
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Power enables
   // ---------------------------------------------------------------
   // A wake-in-progress powers the analog side ahead of the mode change
   // Full wake has no timer here; the host times the deep wake itself,
   // so READY only follows the mode back to normal
   always @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         O_ANALOG_EN <= 1'b1;
         O_REF_EN    <= 1'b1;
         O_MODE      <= `MODE_NORMAL;
         O_READY     <= 1'b1;
      end else begin
         O_ANALOG_EN <= (mode_r == `MODE_NORMAL) | wake_r;
         O_REF_EN    <= (mode_r != `MODE_FULL) | wake_r;
         O_MODE      <= mode_r;
         O_READY     <= (mode_r == `MODE_NORMAL) |
                        (wake_r && mode_r == `MODE_PARTIAL && wake_cnt_r == `WAKE_CYC);
      end
   end

endmodule
`default_nettype wire

/* File: host_port.sv */
`timescale 1ns/1ns
`default_nettype none
module host_port (
   input  wire logic        i_clk,  // Sys clock
   input  wire logic        i_d1,   // Line one
   input  wire logic        i_oe1,  // Line one on
   input  wire logic        i_d2,   // Line two
   input  wire logic        i_oe2,  // Line two on
   output var  logic        o_cs_n, // Select
   output var  logic        o_sclk, // Serial clock
   output var  logic [31:0] o_w1,   // Bits, line one
   output var  logic [31:0] o_w2,   // Bits, line two
   output var  logic        o_got   // Words ready
);
   // Released line reads inverted so a stale level never matches
   wire logic l1 = i_oe1 ? i_d1 : ~i_d1;
   wire logic l2 = i_oe2 ? i_d2 : ~i_d2;
   initial begin
      o_cs_n = 1;
      o_sclk = 1;
      o_got = 0;
   end
   task automatic frame(input int n);
      @(posedge i_clk) #1 o_cs_n = 0;
      o_got = 0;
      o_w1 = 0;
      o_w2 = 0;
      #125;
      repeat (n) begin
         o_sclk = 0;
         #62 o_sclk = 1;
         o_w1 = {o_w1[30:0], l1};
         o_w2 = {o_w2[30:0], l2};
         #63;
      end
      o_cs_n = 1;
      #400 o_got = 1;
   endtask
endmodule
`default_nettype wire

/* File: adc_power_mode_control_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_power_mode_control_monitor (
   input wire logic       I_CLK_SYS,              // Clock
   input wire logic       I_RESETN,               // Reset
   input wire logic       I_CS_N,                 // Select
   input wire logic       O_SERIAL_OUT_FIRST,     // Line one
   input wire logic       O_SERIAL_OUT_FIRST_OE,  // Line one on
   input wire logic       O_SERIAL_OUT_SECOND_OE, // Line two on
   input wire logic       O_SAMPLE,               // Sample
   input wire logic       O_TRACK,                // Track
   input wire logic       O_ANALOG_EN,            // Analog on
   input wire logic       O_REF_EN,               // Reference on
   input wire logic [1:0] O_MODE                  // Mode
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);
   sequence off_s;
      !O_SERIAL_OUT_FIRST_OE && !O_SERIAL_OUT_SECOND_OE;
   endsequence
   sequence fall_s;
      $fell(I_CS_N);
   endsequence
   cs_release_a: assert property ($rose(I_CS_N) |-> ##[1:6] off_s)
      else $error("line driven after select rise");
   idle_off_a: assert property (I_CS_N [*8] |-> off_s)
      else $error("line driven while deselected");
   pair_oe_a: assert property (O_SERIAL_OUT_FIRST_OE == O_SERIAL_OUT_SECOND_OE)
      else $error("line enables differ");
   sample_fall_a: assert property (fall_s |-> ##[2:6] O_SAMPLE)
      else $error("no sample after select fall");
   sample_once_a: assert property (O_SAMPLE |=> !O_SAMPLE [*8])
      else $error("sample not a single pulse");
   hold_on_a: assert property (O_SAMPLE |-> ##[0:1] !O_TRACK)
      else $error("no hold at sample");
   zero_lead_a: assert property ($rose(O_SERIAL_OUT_FIRST_OE) |-> !O_SERIAL_OUT_FIRST)
      else $error("first bit not zero");
   full_ref_a: assert property ((O_MODE == 2'h2 && I_CS_N) [*8] |-> !O_REF_EN)
      else $error("reference on in full power-down");
   part_ref_a: assert property (
      (O_MODE == 2'h1 && I_CS_N) [*8] |-> O_REF_EN && !O_ANALOG_EN)
      else $error("wrong enables in partial power-down");
   mode_hold_a: assert property (!I_CS_N && !$past(I_CS_N) |-> $stable(O_MODE))
      else $error("mode changed inside frame");
endmodule
bind adc_power_mode_control adc_power_mode_control_monitor u_mon (
   .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_CS_N(I_CS_N),
   .O_SERIAL_OUT_FIRST(O_SERIAL_OUT_FIRST), .O_SERIAL_OUT_FIRST_OE(O_SERIAL_OUT_FIRST_OE),
   .O_SERIAL_OUT_SECOND_OE(O_SERIAL_OUT_SECOND_OE), .O_SAMPLE(O_SAMPLE), .O_TRACK(O_TRACK),
   .O_ANALOG_EN(O_ANALOG_EN), .O_REF_EN(O_REF_EN), .O_MODE(O_MODE));
`default_nettype wire

/* File: adc_power_mode_control_test.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_power_mode_control_test;
   // Wake from full is not timed by the core, so the wait is shortened
   localparam int deep_wake_interval = 6000;
   logic        clk, rst_n, cs_n, sclk, d1, oe1, d2, oe2, smp, trk, aen, ren, rdy, got;
   logic [11:0] ra, rb;
   logic [1:0]  mode;
   logic [31:0] w1, w2;
   logic [64:0] q [$];
   int          errors, n_compared;
   int          tn [10] = '{32, 16, 14, 1, 5, 1, 5, 12, 5, 10};
   logic [1:0]  tm [10] = '{0, 0, 0, 0, 1, 1, 2, 0, 1, 0};
   adc_power_mode_control u_dut (
      .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_CS_N(cs_n), .I_SCLK(sclk),
      .I_RESULT_A(ra), .I_RESULT_B(rb), .O_SERIAL_OUT_FIRST(d1),
      .O_SERIAL_OUT_FIRST_OE(oe1), .O_SERIAL_OUT_SECOND(d2),
      .O_SERIAL_OUT_SECOND_OE(oe2), .O_SAMPLE(smp), .O_TRACK(trk),
      .O_ANALOG_EN(aen), .O_REF_EN(ren), .O_MODE(mode), .O_READY(rdy));
   host_port u_host (.i_clk(clk), .i_d1(d1), .i_oe1(oe1), .i_d2(d2), .i_oe2(oe2),
      .o_cs_n(cs_n), .o_sclk(sclk), .o_w1(w1), .o_w2(w2), .o_got(got));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic run(input int n, input logic [1:0] m, input logic c, input logic [11:0] a,
                      input logic [11:0] b);
      int k;
      @(posedge clk) #1 ra = a;
      rb = b;
      q.push_back({c, 32'({1'b0, a, 4'h0, b, 3'h1} >> (32 - n)),
                   32'({1'b0, b, 4'h0, a, 3'h1} >> (32 - n))});
      u_host.frame(n);
      for (k = 0; k < 20 && mode !== m; k++) @(posedge clk);
      check(mode, m);
      check(ren, m != 2'h2);
      check(aen, m == 2'h0);
   endtask
   // --------------------------------------------------------------
   // Result watcher
   // --------------------------------------------------------------
   always @(posedge got) begin : watch
      logic [64:0] e;
      e = q.pop_front();
      if (e[64]) begin
         check(w1, e[63:32]);
         check(w2, e[31:0]);
      end
   end
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst_n = 0;
      ra = 0;
      rb = 0;
      errors = 0;
      n_compared = 0;
      void'($urandom(81));
      repeat (3) @(posedge clk);
      #1 rst_n = 1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         if (i < 10)
            run(tn[i], tm[i], i < 5 || i == 8, 12'($urandom), 12'($urandom));
         else
            run(32, 0, 1, i == 10 ? 12'h000 : 12'($urandom), i == 11 ? 12'hFFF : 12'($urandom));
         if (i == 7) #deep_wake_interval;
         if (i == 9) check(rdy, 1'b1);
         $display("test %0d done", i);
      end
      @(posedge clk);
      tally_and_finish;
   end
endmodule
`default_nettype wire
